// ### card_slot_pkg.sv
// constants and types shared by the card slot control register bank
// assumes a byte-wide register port fed by an already decoded I2C front end
package card_slot_pkg;

   // ==========================================================
   // register addresses
   localparam logic [7:0] ADDR_SLOT_CONTROL = 8'h03;
   localparam logic [7:0] ADDR_SLOT_VIEW    = 8'h42;

   // ==========================================================
   // slot_control_write field positions
   localparam int BIT_LOW_VOLTAGE  = 7;
   localparam int BIT_IO_CONNECT   = 6;
   localparam int BIT_VIEW_HI      = 5;
   localparam int BIT_VIEW_LO      = 4;
   localparam int BIT_CLK_LOW_PWR  = 3;
   localparam int BIT_HIGH_LOW_V   = 2;
   localparam int BIT_RESTART      = 1;
   localparam int BIT_START        = 0;

   // ==========================================================
   // slot_config_view field positions
   localparam int BIT_RESET_LEVEL  = 6;
   localparam int BIT_LP_CLK_HI    = 3;
   localparam int BIT_LP_CLK_LO    = 2;
   localparam int BIT_DIV_HI       = 1;
   localparam int BIT_DIV_LO       = 0;

   // ==========================================================
   // reset values
   localparam logic [7:0]  RST_SHORT_COUNT = 8'hAA;
   localparam logic [7:0]  RST_LONG_HIGH   = 8'hA4;
   localparam logic [7:0]  RST_LONG_LOW    = 8'h74;
   localparam logic [1:0]  RST_LP_CLK      = 2'h0;
   localparam logic [1:0]  RST_DIVIDER     = 2'h0;
   localparam logic        RST_RESET_LEVEL = 1'b0;
   localparam logic [7:0]  READ_UNMAPPED   = 8'h00;

   // ==========================================================
   // clock divider ratios
   localparam logic [3:0] DIV_RATIO_0 = 4'h1;
   localparam logic [3:0] DIV_RATIO_1 = 4'h2;
   localparam logic [3:0] DIV_RATIO_2 = 4'h4;
   localparam logic [3:0] DIV_RATIO_3 = 4'h5;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      VCC_OFF,
      VCC_1V8,
      VCC_3V,
      VCC_5V
   } vcc_type;

   typedef enum logic [1:0] {
      VIEW_CONFIG,
      VIEW_SHORT,
      VIEW_LONG_HIGH,
      VIEW_LONG_LOW
   } view_type;

   typedef enum logic [1:0] {
      CLK_SRC_LOW,
      CLK_SRC_HIGH,
      CLK_SRC_OSC_HALF,
      CLK_SRC_DIV
   } clk_src_type;

endpackage : card_slot_pkg

// ### card_clock_gen.sv
// card clock generator: divides the shared external clock or picks a level
// assumes the external clock pin is far slower than sys_clk (sampled input)
module card_clock_gen (
   input  wire logic                      sys_clk,
   input  wire logic                      rst_n,
   input  wire logic                      ext_clk_pin,
   input  wire card_slot_pkg::clk_src_type clk_src,
   input  wire logic [1:0]                div_code,
   output      logic                      clk_out
);
   import card_slot_pkg::*;

   logic       sync1_ff;
   logic       sync2_ff;
   logic       prev_ff;
   logic [3:0] half_cnt_ff;
   logic       osc_ff;
   logic       clk_ff;
   logic       nxt_sync1;
   logic       nxt_sync2;
   logic       nxt_prev;
   logic [3:0] nxt_half_cnt;
   logic       nxt_osc;
   logic       nxt_clk;
   logic [3:0] ratio;
   logic [3:0] limit;

   function automatic logic [3:0] div_ratio(input logic [1:0] code);
      case (code)
         2'h0:    div_ratio = DIV_RATIO_0;
         2'h1:    div_ratio = DIV_RATIO_1;
         2'h2:    div_ratio = DIV_RATIO_2;
         default: div_ratio = DIV_RATIO_3;
      endcase
   endfunction : div_ratio

   // ==========================================================
   // next state
   always_comb begin
      nxt_sync1    = ext_clk_pin;
      nxt_sync2    = sync1_ff;
      nxt_prev     = sync2_ff;
      ratio        = div_ratio(div_code);
      limit        = 4'((ratio << 1) - 4'h1);
      nxt_half_cnt = half_cnt_ff;
      // every input edge is one half period; a ratio change takes effect
      // at once, even mid period, so the card can see a runt pulse
      if (sync2_ff != prev_ff) begin
         if (half_cnt_ff >= limit) begin
            nxt_half_cnt = 4'h0;
         end else begin
            nxt_half_cnt = 4'(half_cnt_ff + 4'h1);
         end
      end
      nxt_osc = ~osc_ff;
      case (clk_src)
         CLK_SRC_LOW:      nxt_clk = 1'b0;
         CLK_SRC_HIGH:     nxt_clk = 1'b1;
         CLK_SRC_OSC_HALF: nxt_clk = osc_ff;
         CLK_SRC_DIV:      nxt_clk = (nxt_half_cnt < ratio);
         default:          nxt_clk = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sync1_ff    <= 1'b0;
         sync2_ff    <= 1'b0;
         prev_ff     <= 1'b0;
         half_cnt_ff <= 4'h0;
         osc_ff      <= 1'b0;
         clk_ff      <= 1'b0;
      end else begin
         sync1_ff    <= nxt_sync1;
         sync2_ff    <= nxt_sync2;
         prev_ff     <= nxt_prev;
         half_cnt_ff <= nxt_half_cnt;
         osc_ff      <= nxt_osc;
         clk_ff      <= nxt_clk;
      end
   end

   assign clk_out = clk_ff;

endmodule : card_clock_gen

// ### card_slot_control_regs.sv
// control registers of one card slot (slots 3 to 5) behind the I2C front end
// assumes the front end gives one-cycle byte read and write strobes on
// SYS_CLK; sequencer inputs share SYS_CLK, fault and presence pins do not
//
// Summary of operation
// - low voltage select high forces 1.8 V, high/low select ignored
// - low voltage select low: high/low select gives 5 V or 3 V
// - both voltage select bits keep their value while start is set
// - io connect one joins host and card io; zero isolates both
// - clock low power select picks low power setting or divider field
// - in synchronous mode low power select is locked while start set
// - writing restart one launches a warm reset of the slot
// - restart bit clears on detected start bit or no-answer flag
// - start one activates only without faults and with card inserted
// - writing start zero launches the deactivation sequence
// - view select steers register 1 to config, short, long high, long low
// - sync: reset level bit drives reset pin; async: hardware drives it
// - config view: low power setting bits 3:2, divider bits 1:0
// - async low power setting: low, high, half oscillator, divider
// - async divider divides shared clock by one, two, four or five
// - short counter view: 8-bit counter, reset value AAh
// - long counter views: 16-bit counter, resets A4h and 74h
module card_slot_control_regs (
   input  wire logic                  SYS_CLK,
   input  wire logic                  RST_N,
   input  wire logic [7:0]            REG_ADDR,
   input  wire logic                  REG_WR,
   input  wire logic                  REG_RD,
   input  wire logic [7:0]            REG_WDATA,
   output      logic [7:0]            REG_RDATA,
   input  wire logic                  SUPERVISOR_FAULT,
   input  wire logic                  OVERLOAD_FAULT,
   input  wire logic                  CARD_INSERTED,
   input  wire logic                  START_BIT_SEEN,
   input  wire logic                  NO_ANSWER,
   input  wire logic                  ATR_RESET_LEVEL,
   input  wire logic                  SHARED_CLOCK_INPUT,
   output      card_slot_pkg::vcc_type VCC_SELECT,
   output      logic                  IO_CONNECT,
   output      logic                  CARD_RESET,
   output      logic                  CARD_CLK,
   output      logic                  SESSION_ACTIVE,
   output      logic                  ASYNC_MODE,
   output      logic                  ACTIVATE,
   output      logic                  DEACTIVATE,
   output      logic                  WARM_RESET,
   output      logic [7:0]            SHORT_COUNT,
   output      logic [15:0]           LONG_COUNT
);
   import card_slot_pkg::*;

   // ==========================================================
   // pin synchronisers
   logic [2:0] fault_s1_ff;
   logic [2:0] fault_s2_ff;

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         fault_s1_ff <= 3'h0;
         fault_s2_ff <= 3'h0;
      end else begin
         fault_s1_ff <= {SUPERVISOR_FAULT, OVERLOAD_FAULT, CARD_INSERTED};
         fault_s2_ff <= fault_s1_ff;
      end
   end

   logic supervisor_fault;
   logic overload_fault;
   logic card_inserted;
   assign supervisor_fault = fault_s2_ff[2];
   assign overload_fault   = fault_s2_ff[1];
   assign card_inserted    = fault_s2_ff[0];

   // ==========================================================
   // control state
   logic        low_voltage_select_ff;
   logic        high_low_voltage_select_ff;
   logic        io_connect_ff;
   view_type    view_ff;
   logic        clock_low_power_select_ff;
   logic        restart_ff;
   logic        start_ff;
   logic        async_mode_ff;
   logic        card_reset_level_ff;
   logic [1:0]  low_power_clock_setting_ff;
   logic [1:0]  clock_divider_field_ff;
   logic [7:0]  short_count_ff;
   logic [15:0] long_count_ff;
   logic [7:0]  rdata_ff;
   logic        activate_ff;
   logic        deactivate_ff;
   logic        warm_ff;
   vcc_type     vcc_ff;
   logic        card_reset_ff;

   logic        nxt_low_voltage_select;
   logic        nxt_high_low_voltage_select;
   logic        nxt_io_connect;
   view_type    nxt_view;
   logic        nxt_clock_low_power_select;
   logic        nxt_restart;
   logic        nxt_start;
   logic        nxt_async_mode;
   logic        nxt_card_reset_level;
   logic [1:0]  nxt_low_power_clock_setting;
   logic [1:0]  nxt_clock_divider_field;
   logic [7:0]  nxt_short_count;
   logic [15:0] nxt_long_count;
   logic [7:0]  nxt_rdata;
   logic        nxt_activate;
   logic        nxt_deactivate;
   logic        nxt_warm;
   vcc_type     nxt_vcc;
   logic        nxt_card_reset;

   logic        wr_control;
   logic        wr_view;
   logic        sync_session;
   logic [1:0]  eff_lp_setting;
   logic [1:0]  eff_divider;
   clk_src_type clk_src;

   assign wr_control   = REG_WR && (REG_ADDR == ADDR_SLOT_CONTROL);
   assign wr_view      = REG_WR && (REG_ADDR == ADDR_SLOT_VIEW);
   assign sync_session = start_ff && !async_mode_ff;

   always_comb begin
      nxt_low_voltage_select      = low_voltage_select_ff;
      nxt_high_low_voltage_select = high_low_voltage_select_ff;
      nxt_io_connect              = io_connect_ff;
      nxt_view                    = view_ff;
      nxt_clock_low_power_select  = clock_low_power_select_ff;
      nxt_restart                 = restart_ff;
      nxt_start                   = start_ff;
      nxt_async_mode              = async_mode_ff;
      nxt_card_reset_level        = card_reset_level_ff;
      nxt_low_power_clock_setting = low_power_clock_setting_ff;
      nxt_clock_divider_field     = clock_divider_field_ff;
      nxt_short_count             = short_count_ff;
      nxt_long_count              = long_count_ff;
      nxt_activate                = 1'b0;
      nxt_deactivate              = 1'b0;
      nxt_warm                    = 1'b0;
      nxt_rdata                   = rdata_ff;

      // clear first so a same-cycle write of one wins
      if (START_BIT_SEEN || NO_ANSWER) begin
         nxt_restart = 1'b0;
      end

      if (wr_control) begin
         if (!start_ff) begin
            nxt_low_voltage_select      = REG_WDATA[BIT_LOW_VOLTAGE];
            nxt_high_low_voltage_select = REG_WDATA[BIT_HIGH_LOW_V];
         end
         nxt_io_connect = REG_WDATA[BIT_IO_CONNECT];
         nxt_view = view_type'(REG_WDATA[BIT_VIEW_HI:BIT_VIEW_LO]);
         if (!sync_session) begin
            nxt_clock_low_power_select = REG_WDATA[BIT_CLK_LOW_PWR];
         end
         if (REG_WDATA[BIT_RESTART]) begin
            nxt_restart = 1'b1;
            nxt_warm    = 1'b1;
         end
         if (REG_WDATA[BIT_START]) begin
            if (!start_ff && !supervisor_fault && !overload_fault
                && card_inserted) begin
               nxt_start      = 1'b1;
               nxt_activate   = 1'b1;
               // reset level at activation picks card protocol
               nxt_async_mode = card_reset_level_ff;
            end
         end else begin
            nxt_start = 1'b0;
            nxt_deactivate = start_ff;
         end
      end

      if (wr_view) begin
         case (view_ff)
            VIEW_CONFIG: begin
               // reserved bits 7, 5, 4 are not stored
               nxt_card_reset_level = REG_WDATA[BIT_RESET_LEVEL];
               nxt_low_power_clock_setting =
                  REG_WDATA[BIT_LP_CLK_HI:BIT_LP_CLK_LO];
               nxt_clock_divider_field =
                  REG_WDATA[BIT_DIV_HI:BIT_DIV_LO];
            end
            VIEW_SHORT:     nxt_short_count = REG_WDATA;
            VIEW_LONG_HIGH: nxt_long_count[15:8] = REG_WDATA;
            VIEW_LONG_LOW:  nxt_long_count[7:0] = REG_WDATA;
            default:        nxt_short_count = short_count_ff;
         endcase
      end

      // register 0 read side is status logic outside this bank
      if (REG_RD) begin
         if (REG_ADDR == ADDR_SLOT_VIEW) begin
            case (view_ff)
               VIEW_CONFIG: begin
                  nxt_rdata = 8'h00;
                  nxt_rdata[BIT_RESET_LEVEL] = card_reset_ff;
                  nxt_rdata[BIT_LP_CLK_HI:BIT_LP_CLK_LO] = eff_lp_setting;
                  nxt_rdata[BIT_DIV_HI:BIT_DIV_LO] = eff_divider;
               end
               VIEW_SHORT:     nxt_rdata = short_count_ff;
               VIEW_LONG_HIGH: nxt_rdata = long_count_ff[15:8];
               VIEW_LONG_LOW:  nxt_rdata = long_count_ff[7:0];
               default:        nxt_rdata = READ_UNMAPPED;
            endcase
         end else begin
            nxt_rdata = READ_UNMAPPED;
         end
      end

      if (low_voltage_select_ff) begin
         nxt_vcc = VCC_1V8;
      end else if (high_low_voltage_select_ff) begin
         nxt_vcc = VCC_5V;
      end else begin
         nxt_vcc = VCC_3V;
      end

      if (start_ff && async_mode_ff) begin
         nxt_card_reset = ATR_RESET_LEVEL;
      end else begin
         nxt_card_reset = card_reset_level_ff;
      end
   end

   // ==========================================================
   // clock source selection
   always_comb begin
      eff_lp_setting = low_power_clock_setting_ff;
      eff_divider    = clock_divider_field_ff;
      if (sync_session) begin
         // with low power select set, synchronous cards get a level only; the divider is held at zero
         eff_divider = 2'h0;
         if (clock_low_power_select_ff) begin
            eff_lp_setting[1] = 1'b0;
         end
      end
      if (clock_low_power_select_ff) begin
         case (eff_lp_setting)
            2'h0:    clk_src = CLK_SRC_LOW;
            2'h1:    clk_src = CLK_SRC_HIGH;
            2'h2:    clk_src = CLK_SRC_OSC_HALF;
            default: clk_src = CLK_SRC_DIV;
         endcase
      end else begin
         clk_src = CLK_SRC_DIV;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         low_voltage_select_ff      <= 1'b0;
         high_low_voltage_select_ff <= 1'b0;
         io_connect_ff              <= 1'b0;
         view_ff                    <= VIEW_CONFIG;
         clock_low_power_select_ff  <= 1'b0;
         restart_ff                 <= 1'b0;
         start_ff                   <= 1'b0;
         async_mode_ff              <= 1'b0;
         card_reset_level_ff        <= RST_RESET_LEVEL;
         low_power_clock_setting_ff <= RST_LP_CLK;
         clock_divider_field_ff     <= RST_DIVIDER;
         short_count_ff             <= RST_SHORT_COUNT;
         long_count_ff              <= {RST_LONG_HIGH, RST_LONG_LOW};
         rdata_ff                   <= READ_UNMAPPED;
         activate_ff                <= 1'b0;
         deactivate_ff              <= 1'b0;
         warm_ff                    <= 1'b0;
         vcc_ff                     <= VCC_OFF;
         card_reset_ff              <= RST_RESET_LEVEL;
      end else begin
         low_voltage_select_ff      <= nxt_low_voltage_select;
         high_low_voltage_select_ff <= nxt_high_low_voltage_select;
         io_connect_ff              <= nxt_io_connect;
         view_ff                    <= nxt_view;
         clock_low_power_select_ff  <= nxt_clock_low_power_select;
         restart_ff                 <= nxt_restart;
         start_ff                   <= nxt_start;
         async_mode_ff              <= nxt_async_mode;
         card_reset_level_ff        <= nxt_card_reset_level;
         low_power_clock_setting_ff <= nxt_low_power_clock_setting;
         clock_divider_field_ff     <= nxt_clock_divider_field;
         short_count_ff             <= nxt_short_count;
         long_count_ff              <= nxt_long_count;
         rdata_ff                   <= nxt_rdata;
         activate_ff                <= nxt_activate;
         deactivate_ff              <= nxt_deactivate;
         warm_ff                    <= nxt_warm;
         vcc_ff                     <= nxt_vcc;
         card_reset_ff              <= nxt_card_reset;
      end
   end

   // ==========================================================
   // card clock
   card_clock_gen clock_gen (
      .sys_clk     (SYS_CLK),
      .rst_n       (RST_N),
      .ext_clk_pin (SHARED_CLOCK_INPUT),
      .clk_src     (clk_src),
      .div_code    (eff_divider),
      .clk_out     (CARD_CLK)
   );

   assign REG_RDATA      = rdata_ff;
   assign VCC_SELECT     = vcc_ff;
   assign IO_CONNECT     = io_connect_ff;
   assign CARD_RESET     = card_reset_ff;
   assign SESSION_ACTIVE = start_ff;
   assign ASYNC_MODE     = async_mode_ff;
   assign ACTIVATE       = activate_ff;
   assign DEACTIVATE     = deactivate_ff;
   assign WARM_RESET     = warm_ff;
   assign SHORT_COUNT    = short_count_ff;
   assign LONG_COUNT     = long_count_ff;

endmodule : card_slot_control_regs

// ### card_slot_props.sv
// checker: port-level properties of the card slot control register bank
// assumes a bind onto card_slot_control_regs, one SYS_CLK domain
module card_slot_props (
   input wire logic                   SYS_CLK,
   input wire logic                   RST_N,
   input wire logic [7:0]             REG_ADDR,
   input wire logic                   REG_WR,
   input wire logic                   REG_RD,
   input wire logic [7:0]             REG_WDATA,
   input wire logic [7:0]             REG_RDATA,
   input wire logic                   SUPERVISOR_FAULT,
   input wire logic                   OVERLOAD_FAULT,
   input wire logic                   CARD_INSERTED,
   input wire card_slot_pkg::vcc_type VCC_SELECT,
   input wire logic                   IO_CONNECT,
   input wire logic                   SESSION_ACTIVE,
   input wire logic                   ACTIVATE,
   input wire logic                   DEACTIVATE,
   input wire logic                   WARM_RESET
);
   import card_slot_pkg::*;
   // ========
   // helpers
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   logic ctl_wr;
   assign ctl_wr = REG_WR && (REG_ADDR == ADDR_SLOT_CONTROL);
   // ========
   // properties
   act_rise_a: assert property (
      ACTIVATE |-> SESSION_ACTIVE && !$past(SESSION_ACTIVE))
      else $error("activate pulse without session start");
   // pins pass two sync flops and the pulse is registered, so it reflects them three samples back
   act_gate_a: assert property (
      ACTIVATE |-> $past(CARD_INSERTED, 3) && !$past(SUPERVISOR_FAULT, 3)
      && !$past(OVERLOAD_FAULT, 3))
      else $error("activation despite fault or empty slot");
   deact_fall_a: assert property (
      DEACTIVATE |-> !SESSION_ACTIVE && $past(SESSION_ACTIVE))
      else $error("deactivate pulse without session end");
   volt_lock_a: assert property (
      SESSION_ACTIVE && $past(SESSION_ACTIVE) && $past(SESSION_ACTIVE, 2)
      |-> $stable(VCC_SELECT))
      else $error("supply select moved during session");
   volt_live_a: assert property (
      $past(RST_N, 2) |-> VCC_SELECT != VCC_OFF)
      else $error("supply select off outside reset");
   io_follow_a: assert property (
      ctl_wr |=> IO_CONNECT == $past(REG_WDATA[BIT_IO_CONNECT]))
      else $error("io connect does not follow write");
   warm_pulse_a: assert property (
      ctl_wr && REG_WDATA[BIT_RESTART] |=> WARM_RESET)
      else $error("restart write without warm reset");
   rd_zero_a: assert property (
      REG_RD && REG_ADDR != ADDR_SLOT_VIEW |=> REG_RDATA == READ_UNMAPPED)
      else $error("read outside view gave data");
   rd_hold_a: assert property (
      !REG_RD |=> $stable(REG_RDATA))
      else $error("read data changed without read");
   cover property (ACTIVATE ##1 !ACTIVATE);
   cover property (DEACTIVATE);
   cover property (WARM_RESET);
endmodule : card_slot_props

bind card_slot_control_regs card_slot_props card_slot_props_i (.*);

// ### card_side_model.sv
// slot side model: shared external clock and answer-to-reset reply
// assumes activate and warm are one-cycle pulses on clk
module card_side_model #(
   parameter int REPLY_DELAY = 12
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic activate,
   input  wire logic warm,
   output      logic shared_clk,
   output      logic start_seen,
   output      logic atr_level
);
   logic [2:0] ph_ff, nxt_ph;
   logic [7:0] cnt_ff, nxt_cnt;
   logic       lvl_ff, nxt_lvl, seen_ff, nxt_seen;
   // free-running pin at an eighth of clk keeps it under the sync limit
   assign shared_clk = ph_ff[2];
   assign start_seen = seen_ff;
   assign atr_level  = lvl_ff;
   always_comb begin
      nxt_ph   = ph_ff + 3'h1;
      nxt_cnt  = (cnt_ff != 8'h00) ? cnt_ff - 8'h01 : 8'h00;
      nxt_lvl  = lvl_ff;
      nxt_seen = 1'b0;
      if (activate || warm) begin
         nxt_cnt = 8'(REPLY_DELAY);
         nxt_lvl = 1'b0;
      end else if (cnt_ff == 8'h01) begin
         nxt_lvl  = 1'b1;
         nxt_seen = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ph_ff   <= 3'h0;
         cnt_ff  <= 8'h00;
         lvl_ff  <= 1'b0;
         seen_ff <= 1'b0;
      end else begin
         ph_ff   <= nxt_ph;
         cnt_ff  <= nxt_cnt;
         lvl_ff  <= nxt_lvl;
         seen_ff <= nxt_seen;
      end
   end
endmodule : card_side_model

// ### card_slot_control_regs_bench.sv
// self-checking bench for the card slot control register bank
// assumes the bound checker and the slot side model beside the design
module card_slot_control_regs_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import card_slot_pkg::*;
   // ========
   // signals
   logic        sys_clk = 1'b0;
   logic        rst_n   = 1'b0;
   logic [7:0]  addr    = 8'h00;
   logic [7:0]  wdata   = 8'h00;
   logic        reg_wr  = 1'b0;
   logic        reg_rd  = 1'b0;
   logic        sup_f   = 1'b0;
   logic        ovl_f   = 1'b0;
   logic        ins     = 1'b1;
   logic        no_ans  = 1'b0;
   logic        start_seen, atr_lvl, ext_clk, io_con, card_rst, card_clk;
   logic        sess, async_m, act, deact, warm;
   logic [7:0]  rdata, short_c;
   logic [15:0] long_c;
   vcc_type     vcc;
   int          errors = 0;
   int          check_count = 0;
   int          n;
   logic [7:0]  view_rst [4] = '{8'h00, 8'hAA, 8'hA4, 8'h74};
   vcc_type     vcc_exp [4] = '{VCC_3V, VCC_5V, VCC_1V8, VCC_1V8};
   logic [2:0]  bad_pins [3] = '{3'b000, 3'b101, 3'b011};
   always #12.5 sys_clk = ~sys_clk;
   // ========
   // instances
   card_slot_control_regs card_slot_control_regs_i (
      .SYS_CLK(sys_clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
      .SUPERVISOR_FAULT(sup_f), .OVERLOAD_FAULT(ovl_f),
      .CARD_INSERTED(ins), .START_BIT_SEEN(start_seen), .NO_ANSWER(no_ans),
      .ATR_RESET_LEVEL(atr_lvl), .SHARED_CLOCK_INPUT(ext_clk),
      .VCC_SELECT(vcc), .IO_CONNECT(io_con), .CARD_RESET(card_rst),
      .CARD_CLK(card_clk), .SESSION_ACTIVE(sess), .ASYNC_MODE(async_m),
      .ACTIVATE(act), .DEACTIVATE(deact), .WARM_RESET(warm),
      .SHORT_COUNT(short_c), .LONG_COUNT(long_c));
   card_side_model card_side_model_i (
      .clk(sys_clk), .rst_n(rst_n), .activate(act), .warm(warm),
      .shared_clk(ext_clk), .start_seen(start_seen), .atr_level(atr_lvl));
   // ========
   // tasks
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task results;
      if (errors == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results
   task cyc(input int k);
      repeat (k) @(negedge sys_clk);
   endtask : cyc
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr   <= a;
      wdata  <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(negedge sys_clk);
   endtask : wr_reg
   task rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      addr   <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      chk(16'(rdata), 16'(exp));
   endtask : rd_reg
   // pins pass sync flops, so hold them a few cycles before any start
   task pins(input logic [2:0] p);
      @(posedge sys_clk);
      {sup_f, ovl_f, ins} <= p;
      cyc(4);
   endtask : pins
   // card clock transitions over 80 cycles, once a new ratio has settled
   task clk_edges(input logic [7:0] cfg, input logic [7:0] exp);
      logic prev;
      int   k;
      wr_reg(ADDR_SLOT_VIEW, cfg);
      cyc(60);
      k = 0;
      prev = card_clk;
      repeat (80) begin
         cyc(1);
         if (card_clk !== prev)
            k++;
         prev = card_clk;
      end
      chk(16'(k), 16'(exp));
   endtask : clk_edges
   // ========
   // sequence
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      cyc(3);
      chk(16'(vcc), 16'(VCC_3V));
      chk(16'(short_c), 16'h00AA);
      chk(long_c, 16'hA474);
      for (int v = 1; v < 4; v++) begin
         wr_reg(ADDR_SLOT_CONTROL, 8'(v << 4));
         rd_reg(ADDR_SLOT_VIEW, view_rst[v]);
         wr_reg(ADDR_SLOT_VIEW, 8'h50 + 8'(v));
         rd_reg(ADDR_SLOT_VIEW, 8'h50 + 8'(v));
      end
      chk(16'(short_c), 16'h0051);
      chk(long_c, 16'h5253);
      wr_reg(ADDR_SLOT_CONTROL, 8'h00);
      wr_reg(ADDR_SLOT_VIEW, 8'hB6);
      rd_reg(ADDR_SLOT_VIEW, 8'h06);
      rd_reg(8'h10, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr_reg(ADDR_SLOT_CONTROL, {i[1], 4'h0, i[0], 2'h0});
         cyc(1);
         chk(16'(vcc), 16'(vcc_exp[i]));
      end
      // io connect one joins this slot to the host line, zero isolates it
      wr_reg(ADDR_SLOT_CONTROL, 8'h40);
      chk(16'(io_con), 16'h0001);
      wr_reg(ADDR_SLOT_CONTROL, 8'h00);
      chk(16'(io_con), 16'h0000);
      for (int i = 0; i < 3; i++) begin
         pins(bad_pins[i]);
         wr_reg(ADDR_SLOT_CONTROL, 8'h01);
         chk(16'({act, sess}), 16'h0000);
      end
      pins(3'b001);
      wr_reg(ADDR_SLOT_VIEW, 8'h04);
      wr_reg(ADDR_SLOT_CONTROL, 8'h0D);
      chk(16'({act, sess, async_m}), 16'h0006);
      wr_reg(ADDR_SLOT_CONTROL, 8'h81);
      cyc(4);
      chk(16'(vcc), 16'(VCC_5V));
      repeat (12) begin
         cyc(1);
         chk(16'(card_clk), 16'h0001);
      end
      wr_reg(ADDR_SLOT_VIEW, 8'h44);
      cyc(1);
      chk(16'(card_rst), 16'h0001);
      rd_reg(ADDR_SLOT_VIEW, 8'h44);
      wr_reg(ADDR_SLOT_CONTROL, 8'h83);
      chk(16'(warm), 16'h0001);
      wr_reg(ADDR_SLOT_CONTROL, 8'h00);
      chk(16'({deact, sess}), 16'h0002);
      wr_reg(ADDR_SLOT_VIEW, 8'h40);
      wr_reg(ADDR_SLOT_CONTROL, 8'h09);
      chk(16'({sess, async_m}), 16'h0003);
      // the model drops its level at activation, so the pin must fall first
      cyc(2);
      chk(16'(card_rst), 16'h0000);
      n = 0;
      while (card_rst !== 1'b1 && n < 40) begin
         cyc(1);
         n++;
      end
      chk(16'(card_rst), 16'h0001);
      if (n < 40) begin
         chk(16'(card_clk), 16'h0000);
         clk_edges(8'h4C, 8'h14);
         clk_edges(8'h4D, 8'h0A);
         clk_edges(8'h4E, 8'h05);
         clk_edges(8'h4F, 8'h04);
         clk_edges(8'h48, 8'h50);
         wr_reg(ADDR_SLOT_CONTROL, 8'h00);
      end
      results();
   end
endmodule : card_slot_control_regs_bench
